// >>> common/serial_port_pkg.sv
package serial_port_pkg;

    // =====================================================================
    // clock and line rates
    // =====================================================================
    localparam int unsigned CLK_HZ        = 25000000;   // system clock rate
    localparam int unsigned BAUD_COUNT    = 6;          // number of selectable rates
    localparam int unsigned OVS           = 16;         // receive oversampling
    localparam logic [2:0]  BAUD_DEFAULT  = 3'h5;       // index of 9600 baud

    // divider reload per rate index, one tick per oversample
    function automatic logic [15:0] baud_div(input logic [2:0] sel);
        int unsigned rate;
        case (sel)
            3'h0:    rate = 300;
            3'h1:    rate = 600;
            3'h2:    rate = 1200;
            3'h3:    rate = 2400;
            3'h4:    rate = 4800;
            default: rate = 9600;
        endcase
        return 16'(CLK_HZ / (rate * OVS) - 1);
    endfunction

    // =====================================================================
    // character formats
    // =====================================================================
    typedef enum logic [1:0] {
        FMT_NONE_8 = 2'h0,                               // no parity, 8 data bits
        FMT_EVEN_7 = 2'h1,                               // even parity, 7 data bits
        FMT_ODD_7  = 2'h2                                // odd parity, 7 data bits
    } fmt_t;

    localparam int unsigned STOP_BITS     = 2;          // fixed stop bit count
    localparam int unsigned DATA_BITS_MAX = 8;          // widest data field

    // =====================================================================
    // register map (wishbone, byte addresses)
    // =====================================================================
    localparam logic [3:0] ADR_CTRL   = 4'h0;           // baud and format select
    localparam logic [3:0] ADR_STATUS = 4'h4;           // line and fifo state
    localparam logic [3:0] ADR_TXDATA = 4'h8;           // write a character to send
    localparam logic [3:0] ADR_RXDATA = 4'hC;           // read a received character

    localparam int unsigned CTRL_BAUD_LSB = 0;          // baud index field
    localparam int unsigned CTRL_FMT_LSB  = 4;          // format field
    localparam int unsigned CTRL_REN_BIT  = 8;          // receive enable, drives terminal ready

    localparam int unsigned ST_TXFULL  = 0;             // transmit fifo full
    localparam int unsigned ST_RXVALID = 1;             // receive data waiting
    localparam int unsigned ST_TXBUSY  = 2;             // a frame is on the line
    localparam int unsigned ST_PEER    = 3;             // set-ready from peer
    localparam int unsigned ST_PERR    = 4;             // sticky parity error
    localparam int unsigned ST_FERR    = 5;             // sticky framing error
    localparam int unsigned ST_OVR     = 6;             // sticky receive overrun

endpackage

// >>> verif/host_serial_model.sv
`timescale 1ns/1ps

// =====================================================================
// host side serial port, same rate and format as the device
// =====================================================================
module host_serial_model #(
    parameter int BIT_CYC = 2592                        // cycles per bit, 16 x 162; device ticks are 162 cycles apart, 2592 per bit at 9600
) (
    // clock
    input  wire logic clk_i,
    // serial line seen from the host
    input  wire logic txd_i,
    input  wire logic term_ready_i,
    output logic      rxd_o,
    output logic      set_ready_o
);
    // idle line, host not ready until the bench says so
    initial begin
        rxd_o = 1'b1;
        set_ready_o = 1'b0;
    end

    // capture one frame from the device, sampled at mid-bit
    task automatic grab(output logic [10:0] f);
        int i;
        f = '0;
        for (i = 0; i < 5000 && txd_i; i++) @(posedge clk_i);
        repeat (BIT_CYC / 2) @(posedge clk_i);
        for (i = 0; i < 11; i++) begin
            f[i] = txd_i;
            repeat (BIT_CYC) @(posedge clk_i);
        end
    endtask

    // send one frame, start first, data lsb first, two stops
    task automatic send(input logic [10:0] f);
        int w;
        for (w = 0; w < 1000 && !term_ready_i; w++) @(posedge clk_i); // wait for device ready
        for (int i = 0; i < 11; i++) begin
            rxd_o <= f[i];
            repeat (BIT_CYC) @(posedge clk_i);
        end
        rxd_o <= 1'b1;
    endtask
endmodule

// >>> verif/instrument_serial_port_test.sv
`timescale 1ns/1ps

// =====================================================================
// bench for the serial port
// =====================================================================
module instrument_serial_port_test;
    import serial_port_pkg::*;
    logic        clk_i = 1'b0;                          // 25 MHz clock
    logic        rst_i = 1'b1;                          // synchronous reset
    logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [3:0]  adr_i = 4'h0, sel_i = 4'hF;
    logic [31:0] dat_i = 32'h0, dat_o, q;
    logic        ack_o, txd_o, rxd_i, term_ready_o, set_ready_i;
    logic [10:0] f;                                     // captured frame
    int          err_count = 0, check_count = 0;

    always #20 clk_i = ~clk_i;

    instrument_serial_port i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .txd_o(txd_o),
        .rxd_i(rxd_i), .term_ready_o(term_ready_o), .set_ready_i(set_ready_i));
    host_serial_model i_host (.clk_i(clk_i), .txd_i(txd_o), .term_ready_i(term_ready_o), .rxd_o(rxd_i),
        .set_ready_o(set_ready_i));

    // verdict and end of run
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // one compare, counted
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // classic wishbone single cycle, held until ack
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
        int i;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= 4'hF;
        dat_i <= d;
        for (i = 0; i < 50; i++) begin
            @(posedge clk_i);
            if (ack_o === 1'b1) break;
        end
        r = dat_o;
        if (i == 50) begin
            err_count++;
            tally_and_finish();
        end
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // reset state, default settings, unmapped read
    task automatic t_defaults;
        chk("term_ready", 32'h1, 32'(term_ready_o));
        chk("txd idle", 32'h1, 32'(txd_o));
        wb(1'b0, ADR_CTRL, 32'h0, q);
        chk("ctrl reset", 32'h00000105, q);
        wb(1'b0, 4'h2, 32'h0, q);
        chk("unmapped", 32'h0, q);
    endtask

    // fill the fifo while the host holds off, then reset mid-run
    task automatic t_fill;
        for (int i = 0; i < 17; i++) wb(1'b1, ADR_TXDATA, 32'(i), q);
        repeat (3000) @(posedge clk_i);
        chk("txd held", 32'h1, 32'(txd_o));
        wb(1'b0, ADR_STATUS, 32'h0, q);
        chk("full not busy", 32'h1, 32'(q[3:0]));
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask

    // host ready, one none/8 frame on the line
    task automatic t_send;
        i_host.set_ready_o <= 1'b1;
        repeat (3) @(posedge clk_i);
        wb(1'b0, ADR_STATUS, 32'h0, q);
        chk("status after reset", 32'h8, 32'(q[6:0]));
        wb(1'b1, ADR_TXDATA, 32'h000000A5, q);
        i_host.grab(f);
        chk("tx frame", {21'h0, 2'b11, 8'hA5, 1'b0}, 32'(f));
    endtask

    // even then odd seven-bit characters into the device
    task automatic t_receive;
        logic [10:0] fr;                                // same frame in both directions
        for (int m = 1; m < 3; m++) begin
            wb(1'b1, ADR_CTRL, 32'h105 | 32'(m << 4), q);
            wb(1'b0, ADR_CTRL, 32'h0, q);
            chk("ctrl fmt", 32'h105 | 32'(m << 4), q);
            fr = {2'b11, (^7'h53) ^ (m == 2), 7'h53, 1'b0};
            wb(1'b1, ADR_TXDATA, 32'h53, q);
            fork
                i_host.send(fr); // first character of the remote command
                i_host.grab(f);
            join
            chk("tx parity frame", 32'(fr), 32'(f));
            repeat (4) @(posedge clk_i);
            chk("term_ready busy", 32'h0, 32'(term_ready_o));
            wb(1'b0, ADR_STATUS, 32'h0, q);
            chk("rx status", 32'h1, 32'({q[6:4], q[1]}));
            wb(1'b0, ADR_RXDATA, 32'h0, q);
            chk("rx char", 32'h53, 32'(q[6:0]));
            @(posedge clk_i);
            chk("term_ready free", 32'h1, 32'(term_ready_o));
        end
    endtask

    // main sequence
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        t_defaults();
        t_fill();
        t_send();
        t_receive();
        tally_and_finish();
    end
endmodule

// >>> verilog/char_fifo.sv
`timescale 1ns/1ps

// =====================================================================
// small synchronous fifo, flip-flop storage
// =====================================================================
module char_fifo #(
    parameter int unsigned WIDTH = 8,                   // word width
    parameter int unsigned DEPTH = 16                   // word count
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];                    // storage
    logic [AW-1:0]    wptr_r, wptr_nxt;                 // write index
    logic [AW-1:0]    rptr_r, rptr_nxt;                 // read index
    logic [AW:0]      cnt_r,  cnt_nxt;                  // fill level
    logic             push, pop;                        // handshakes

    // next pointers and level
    always_comb begin
        push     = in_valid_i && (cnt_r != (AW+1)'(DEPTH));
        pop      = out_ready_i && (cnt_r != '0);
        wptr_nxt = push ? AW'(wptr_r + 1'b1) : wptr_r;
        rptr_nxt = pop  ? AW'(rptr_r + 1'b1) : rptr_r;
        cnt_nxt  = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end

    // register state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wptr_r <= '0;
            rptr_r <= '0;
            cnt_r  <= '0;
        end else begin
            wptr_r <= wptr_nxt;
            rptr_r <= rptr_nxt;
            cnt_r  <= cnt_nxt;
        end
        if (push) begin
            mem_r[wptr_r] <= in_data_i;
        end
    end

    assign in_ready_o  = (cnt_r != (AW+1)'(DEPTH));     // honest full
    assign out_valid_o = (cnt_r != '0);                 // honest empty
    assign out_data_o  = mem_r[rptr_r];
endmodule

// >>> verilog/instrument_serial_port.sv
// Chosen here: the address map and register access over Wishbone.
`timescale 1ns/1ps

// Operation
// R1: six selectable rates, default 9600 baud
// R2: formats none/8, even/7, odd/7; default none/8
// R3: exactly one start bit per frame
// R4: exactly two stop bits per frame
// R5: start, data, optional parity, two stops
// R6: DTE pacing: terminal-ready out, set-ready in
// R7: rate and format set by local selection
// R8: host matches rate, format and stops
// R9: host sends remote command before others
// R10: LSB first; parity even/odd over seven bits
// R11: ready only when accepting; respect peer ready

module instrument_serial_port
    import serial_port_pkg::*;
#(
    parameter int unsigned FIFO_DEPTH = 16               // transmit fifo depth
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // serial line
    output logic             txd_o,
    input  wire logic        rxd_i,
    output logic             term_ready_o,
    input  wire logic        set_ready_i
);

    // =====================================================================
    // control registers
    // =====================================================================
    logic [2:0]  baud_sel_r, baud_sel_nxt;               // rate index
    fmt_t        fmt_r, fmt_nxt;                         // character format
    logic        ren_r, ren_nxt;                         // software allows receive
    logic        ack_r, ack_nxt;                         // bus answer
    logic [31:0] dat_r, dat_nxt;                         // read data
    logic        perr_r, perr_nxt;                       // sticky parity error
    logic        ferr_r, ferr_nxt;                       // sticky framing error
    logic        ovr_r, ovr_nxt;                         // sticky overrun
    logic [7:0]  rxbuf_r, rxbuf_nxt;                     // received character
    logic        rxv_r, rxv_nxt;                         // received character waiting

    // =====================================================================
    // oversample tick divider
    // =====================================================================
    logic [15:0] div_r, div_nxt;
    logic        tick_r, tick_nxt;                       // one-cycle enable

    // divider reloads from the selected rate
    always_comb begin
        tick_nxt = 1'b0;
        div_nxt  = div_r - 16'h0001;
        if (div_r == 16'h0000) begin
            div_nxt  = baud_div(baud_sel_r);            // [R1]
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_r  <= 16'h0000;
            tick_r <= 1'b0;
        end else begin
            div_r  <= div_nxt;
            tick_r <= tick_nxt;
        end
    end

    // =====================================================================
    // transmit fifo
    // =====================================================================
    logic       bus_req;                                 // new bus access
    logic       tx_push;                                 // software writes a character
    logic       txf_ready;                               // fifo has room
    logic       txf_valid;                               // fifo holds a character
    logic [7:0] txf_data;
    logic       tx_pop;                                  // serializer takes it

    assign bus_req = cyc_i && stb_i && !ack_r;
    assign tx_push = bus_req && we_i && (adr_i == ADR_TXDATA) && sel_i[0];

    char_fifo #(
        .WIDTH (DATA_BITS_MAX),
        .DEPTH (FIFO_DEPTH)
    ) u_txfifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (tx_push),
        .in_ready_o  (txf_ready),
        .in_data_i   (dat_i[7:0]),
        .out_valid_o (txf_valid),
        .out_ready_i (tx_pop),
        .out_data_o  (txf_data)
    );

    // =====================================================================
    // transmitter
    // =====================================================================
    typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} tx_state_t;
    tx_state_t  tx_st_r, tx_st_nxt;
    logic [10:0] tx_sh_r, tx_sh_nxt;                     // frame bits, lsb goes first
    logic [3:0]  tx_bits_r, tx_bits_nxt;                 // bits left in frame
    logic [3:0]  tx_os_r, tx_os_nxt;                     // ticks within a bit
    logic        txd_r, txd_nxt;
    logic        par7;                                   // even parity of seven bits

    assign par7   = ^txf_data[6:0];
    assign tx_pop = (tx_st_r == TX_IDLE) && txf_valid && set_ready_i && tick_r; // [R11]

    // frame build and shift
    always_comb begin
        tx_st_nxt   = tx_st_r;
        tx_sh_nxt   = tx_sh_r;
        tx_bits_nxt = tx_bits_r;
        tx_os_nxt   = tx_os_r;
        txd_nxt     = txd_r;
        case (tx_st_r)
            TX_IDLE: begin
                txd_nxt = 1'b1;
                if (tx_pop) begin
                    // stop,stop,(parity|d7),d6..d0 then the start bit goes out now
                    case (fmt_r)
                        FMT_EVEN_7: tx_sh_nxt = {2'b11, par7, txf_data[6:0], 1'b0};   // [R5] [R10]
                        FMT_ODD_7:  tx_sh_nxt = {2'b11, ~par7, txf_data[6:0], 1'b0};  // [R5] [R10]
                        default:    tx_sh_nxt = {2'b11, txf_data, 1'b0};             // [R5]
                    endcase
                    txd_nxt     = 1'b0;                  // one start bit [R3]
                    tx_bits_nxt = 4'hA;                  // 8 payload + 2 stops follow [R4]
                    tx_os_nxt   = 4'(OVS - 1);
                    tx_st_nxt   = TX_SHIFT;
                end
            end
            TX_SHIFT: begin
                if (tick_r) begin
                    tx_os_nxt = tx_os_r - 4'h1;
                    if (tx_os_r == 4'h0) begin
                        tx_os_nxt = 4'(OVS - 1);
                        if (tx_bits_r == 4'h0) begin
                            tx_st_nxt = TX_IDLE;
                            txd_nxt   = 1'b1;
                        end else begin
                            tx_sh_nxt   = {1'b1, tx_sh_r[10:1]};
                            txd_nxt     = tx_sh_r[1];    // lsb first [R10]
                            tx_bits_nxt = tx_bits_r - 4'h1;
                        end
                    end
                end
            end
            default: tx_st_nxt = TX_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_st_r   <= TX_IDLE;
            tx_sh_r   <= '1;
            tx_bits_r <= 4'h0;
            tx_os_r   <= 4'h0;
            txd_r     <= 1'b1;
        end else begin
            tx_st_r   <= tx_st_nxt;
            tx_sh_r   <= tx_sh_nxt;
            tx_bits_r <= tx_bits_nxt;
            tx_os_r   <= tx_os_nxt;
            txd_r     <= txd_nxt;
        end
    end

    // =====================================================================
    // receiver
    // =====================================================================
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} rx_state_t;
    rx_state_t  rx_st_r, rx_st_nxt;
    logic [7:0] rx_sh_r, rx_sh_nxt;                      // data plus parity bits
    logic [3:0] rx_cnt_r, rx_cnt_nxt;                    // bits taken
    logic [3:0] rx_os_r, rx_os_nxt;                      // ticks within a bit
    logic       rx_done;                                 // character complete
    logic       rx_perr, rx_ferr;
    logic [7:0] rx_char;

    // sample mid-bit, collect eight payload bits, check both stops
    always_comb begin
        rx_st_nxt  = rx_st_r;
        rx_sh_nxt  = rx_sh_r;
        rx_cnt_nxt = rx_cnt_r;
        rx_os_nxt  = rx_os_r;
        rx_done    = 1'b0;
        rx_ferr    = 1'b0;
        if (tick_r) begin
            rx_os_nxt = rx_os_r - 4'h1;
            case (rx_st_r)
                RX_IDLE: begin
                    if (!rxd_i) begin
                        rx_st_nxt = RX_START;
                        rx_os_nxt = 4'(OVS/2 - 1);
                    end
                end
                RX_START: begin
                    if (rx_os_r == 4'h0) begin
                        rx_os_nxt  = 4'(OVS - 1);
                        rx_cnt_nxt = 4'h0;
                        rx_st_nxt  = rxd_i ? RX_IDLE : RX_BITS;  // glitch rejected [R3]
                    end
                end
                RX_BITS: begin
                    if (rx_os_r == 4'h0) begin
                        rx_os_nxt  = 4'(OVS - 1);
                        rx_sh_nxt  = {rxd_i, rx_sh_r[7:1]};      // lsb first [R10]
                        rx_cnt_nxt = rx_cnt_r + 4'h1;
                        if (rx_cnt_r == 4'(DATA_BITS_MAX - 1)) begin
                            rx_cnt_nxt = 4'h0;
                            rx_st_nxt  = RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (rx_os_r == 4'h0) begin
                        rx_os_nxt  = 4'(OVS - 1);
                        rx_cnt_nxt = rx_cnt_r + 4'h1;
                        if (!rxd_i) begin
                            rx_ferr   = 1'b1;           // missing stop bit [R4]
                            rx_st_nxt = RX_IDLE;
                        end else if (rx_cnt_r == 4'(STOP_BITS - 1)) begin
                            rx_done   = 1'b1;
                            rx_st_nxt = RX_IDLE;
                        end
                    end
                end
                default: rx_st_nxt = RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_st_r  <= RX_IDLE;
            rx_sh_r  <= 8'h00;
            rx_cnt_r <= 4'h0;
            rx_os_r  <= 4'h0;
        end else begin
            rx_st_r  <= rx_st_nxt;
            rx_sh_r  <= rx_sh_nxt;
            rx_cnt_r <= rx_cnt_nxt;
            rx_os_r  <= rx_os_nxt;
        end
    end

    // parity check and character strip
    always_comb begin
        case (fmt_r)
            FMT_EVEN_7: begin
                rx_perr = ^rx_sh_r;                      // [R10]
                rx_char = {1'b0, rx_sh_r[6:0]};
            end
            FMT_ODD_7: begin
                rx_perr = ~^rx_sh_r;                     // [R10]
                rx_char = {1'b0, rx_sh_r[6:0]};
            end
            default: begin
                rx_perr = 1'b0;
                rx_char = rx_sh_r;
            end
        endcase
    end

    // =====================================================================
    // bus slave and status
    // =====================================================================
    logic rx_read;                                       // software takes the character
    assign rx_read = bus_req && !we_i && (adr_i == ADR_RXDATA);

    // register writes, reads and sticky flags; hardware set wins over clear
    always_comb begin
        baud_sel_nxt = baud_sel_r;
        fmt_nxt      = fmt_r;
        ren_nxt      = ren_r;
        perr_nxt     = perr_r;
        ferr_nxt     = ferr_r;
        ovr_nxt      = ovr_r;
        rxbuf_nxt    = rxbuf_r;
        rxv_nxt      = rxv_r;
        ack_nxt      = bus_req;
        dat_nxt      = 32'h0000_0000;
        if (bus_req && !we_i) begin
            case (adr_i)
                ADR_CTRL:   dat_nxt = {23'h0, ren_r, 2'b00, fmt_r, 1'b0, baud_sel_r};
                ADR_STATUS: dat_nxt = {25'h0, ovr_r, ferr_r, perr_r, set_ready_i,
                                       (tx_st_r != TX_IDLE), rxv_r, !txf_ready};
                ADR_RXDATA: dat_nxt = {24'h0, rxbuf_r};
                default:    dat_nxt = 32'h0000_0000;     // unmapped reads zero
            endcase
        end
        if (rx_read) begin
            rxv_nxt = 1'b0;
        end
        if (bus_req && we_i && (adr_i == ADR_CTRL) && sel_i[0]) begin
            baud_sel_nxt = (dat_i[2:0] > 3'(BAUD_COUNT - 1)) ? BAUD_DEFAULT : dat_i[2:0]; // [R1] [R7]
            fmt_nxt      = (dat_i[5:4] == 2'h3) ? FMT_NONE_8 : fmt_t'(dat_i[5:4]);        // [R2] [R7]
        end
        if (bus_req && we_i && (adr_i == ADR_CTRL) && sel_i[1]) begin
            ren_nxt = dat_i[CTRL_REN_BIT];
        end
        if (bus_req && we_i && (adr_i == ADR_STATUS) && sel_i[0]) begin
            perr_nxt = perr_r & ~dat_i[ST_PERR];         // write one to clear
            ferr_nxt = ferr_r & ~dat_i[ST_FERR];
            ovr_nxt  = ovr_r  & ~dat_i[ST_OVR];
        end
        if (rx_ferr) begin
            ferr_nxt = 1'b1;
        end
        if (rx_done) begin
            if (rxv_r && !rx_read) begin
                ovr_nxt = 1'b1;                          // old character kept
            end else begin
                rxbuf_nxt = rx_char;
                rxv_nxt   = 1'b1;
                perr_nxt  = perr_nxt | rx_perr;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            baud_sel_r <= BAUD_DEFAULT;                  // 9600 after reset [R1]
            fmt_r      <= FMT_NONE_8;                    // none / 8 after reset [R2]
            ren_r      <= 1'b1;
            ack_r      <= 1'b0;
            dat_r      <= 32'h0000_0000;
            perr_r     <= 1'b0;
            ferr_r     <= 1'b0;
            ovr_r      <= 1'b0;
            rxbuf_r    <= 8'h00;
            rxv_r      <= 1'b0;
            term_ready_o <= 1'b0;
        end else begin
            baud_sel_r <= baud_sel_nxt;
            fmt_r      <= fmt_nxt;
            ren_r      <= ren_nxt;
            ack_r      <= ack_nxt;
            dat_r      <= dat_nxt;
            perr_r     <= perr_nxt;
            ferr_r     <= ferr_nxt;
            ovr_r      <= ovr_nxt;
            rxbuf_r    <= rxbuf_nxt;
            rxv_r      <= rxv_nxt;
            term_ready_o <= ren_nxt && !rxv_nxt;         // ready only with room [R6] [R11]
        end
    end

    assign ack_o = ack_r;
    assign dat_o = dat_r;
    assign txd_o = txd_r;

    // =====================================================================
    // assertions
    // =====================================================================
    property p_idle_high;
        @(posedge clk_i) disable iff (rst_i) (tx_st_r == TX_IDLE && !tx_pop) |=> txd_o;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("line not idle high"); // [R4]

    property p_start_low;
        @(posedge clk_i) disable iff (rst_i) tx_pop |=> !txd_o && tx_st_r == TX_SHIFT;
    endproperty
    a_start_low: assert property (p_start_low) else $error("no start bit"); // [R3]

    property p_peer_gate;
        @(posedge clk_i) disable iff (rst_i) (!set_ready_i && tx_st_r == TX_IDLE) |=> tx_st_r == TX_IDLE;
    endproperty
    a_peer_gate: assert property (p_peer_gate) else $error("sent while peer not ready"); // [R11]

    property p_stop_len;
        @(posedge clk_i) disable iff (rst_i) tx_pop |=> (tx_bits_r == 4'hA);
    endproperty
    a_stop_len: assert property (p_stop_len) else $error("bad frame length"); // [R4]

    property p_parity;
        @(posedge clk_i) disable iff (rst_i) (tx_pop && fmt_r == FMT_EVEN_7) |=> ^tx_sh_r[8:1] == 1'b0;
    endproperty
    a_parity: assert property (p_parity) else $error("even parity wrong"); // [R10]

    property p_rate_legal;
        @(posedge clk_i) disable iff (rst_i) baud_sel_r <= 3'(BAUD_COUNT - 1);
    endproperty
    a_rate_legal: assert property (p_rate_legal) else $error("illegal rate index"); // [R1]

    property p_fmt_legal;
        @(posedge clk_i) disable iff (rst_i) fmt_r != fmt_t'(2'h3);
    endproperty
    a_fmt_legal: assert property (p_fmt_legal) else $error("illegal format"); // [R2]

    property p_ready_full;
        @(posedge clk_i) disable iff (rst_i) rxv_r |-> !term_ready_o;
    endproperty
    a_ready_full: assert property (p_ready_full) else $error("ready while holding data"); // [R6]

    property p_ack_pulse;
        @(posedge clk_i) disable iff (rst_i) ack_o |=> !ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

    c_frame: cover property (@(posedge clk_i) disable iff (rst_i) tx_pop);
    c_rx:    cover property (@(posedge clk_i) disable iff (rst_i) rx_done);
    c_ferr:  cover property (@(posedge clk_i) disable iff (rst_i) rx_ferr);
    c_full:  cover property (@(posedge clk_i) disable iff (rst_i) !txf_ready);
endmodule
